/* File: ptp_tx_ts_top.sv */
/*
 * Transmit PTP timestamp qualification and message modification for
 * one Ethernet port, with its banked APB register file.
 * Assumes the transmit frame path on the same clock gives a header
 * strobe with parsed fields, then an end strobe with FCS and UDP
 * checksum verdicts, one frame at a time.
 */
`timescale 1ns/1ps
module ptp_tx_ts_top
    import ptp_tx_pkg::*;
(
    // Clock and reset
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst,
    // APB slave
    input  wire logic                i_psel,
    input  wire logic                i_penable,
    input  wire logic                i_pwrite,
    input  wire logic [APB_AW-1:0]   i_paddr,
    input  wire logic [31:0]         i_pwdata,
    output logic                     o_pready,
    output logic [31:0]              o_prdata,
    output logic                     o_pslverr,
    // Transmit frame path
    input  wire logic                i_hdr_valid,
    input  wire logic [3:0]          i_msg_type,
    input  wire logic [3:0]          i_version,
    input  wire logic [7:0]          i_domain,
    input  wire logic                i_alt_master,
    input  wire logic                i_is_udp4,
    input  wire logic [29:0]         i_egress_ns,
    input  wire logic [29:0]         i_pdreq_ingress_ns,
    input  wire logic                i_frame_end,
    input  wire logic                i_fcs_ok,
    input  wire logic                i_udp_csum_ok,
    // Modification controls to the frame path
    output logic                     o_insert_origin,
    output logic                     o_insert_turnaround,
    output logic                     o_clear_udp_csum,
    output logic [5:0]               o_reserved_offset,
    output logic [29:0]              o_origin_ns,
    output logic [29:0]              o_turnaround_ns,
    // Timestamp verdict, one-cycle pulses at frame end
    output logic                     o_ts_record,
    output logic                     o_ts_discard
);

    // ------------
    // Register state
    // ------------
    logic                unit_en_r;
    logic [2:0]          bank_r;
    logic [7:0]          domain_r;
    logic                domain_en_r;
    logic                alt_en_r;
    logic                udp_byp_r;
    logic                fcs_byp_r;
    logic [3:0]          version_r;
    logic [15:0]         msg_en_r;
    logic                ta_ins_r;
    logic                sync_ins_r;
    logic [5:0]          rsvd_ofs_r;
    logic                csum_clr_r;
    logic [7:0]          rec_cnt_r;
    logic [7:0]          disc_cnt_r;

    logic                wr_en;
    logic                rd_en;
    logic                port_bank;
    logic                hit;
    logic [31:0]         rd_data;

    function automatic logic [29:0] ns_diff(input logic [29:0] a,
                                            input logic [29:0] b);
        logic [29:0] d;
        d = a - b;
        // Egress after a seconds rollover wraps below ingress
        if (a < b) begin
            d = d + NS_PER_SEC;
        end
        return d;
    endfunction : ns_diff

    // ------------
    // APB access decode
    // ------------
    // Answer one cycle into the access phase: pready, data and error
    // all come from flops, so the access phase is two cycles long.
    assign wr_en     = i_psel && i_penable && !o_pready && i_pwrite;
    assign rd_en     = i_psel && i_penable && !o_pready && !i_pwrite;
    assign port_bank = (bank_r == PORT_BANK);

    always_comb begin
        hit     = 1'b1;
        rd_data = 32'h0000_0000;
        case (i_paddr)
            CMD_CTL_OFS: begin
                rd_data[UNIT_EN_BIT] = unit_en_r;
            end
            BANK_SEL_OFS: begin
                rd_data[2:0] = bank_r;
            end
            STATUS_OFS: begin
                rd_data[15:0] = {disc_cnt_r, rec_cnt_r};
            end
            QUAL_CFG_OFS: begin
                hit     = port_bank;
                rd_data = {domain_r, domain_en_r, alt_en_r, udp_byp_r,
                           fcs_byp_r, version_r, msg_en_r};
                if (!port_bank) begin
                    rd_data = 32'h0000_0000;
                end
            end
            MOD_CFG_OFS: begin
                hit = port_bank;
                if (port_bank) begin
                    rd_data[TA_INS_BIT]   = ta_ins_r;
                    rd_data[SYNC_INS_BIT] = sync_ins_r;
                    rd_data[RSVD_OFS_LSB +: 6] = rsvd_ofs_r;
                end
            end
            MOD_CFG2_OFS: begin
                hit = port_bank;
                if (port_bank) begin
                    rd_data[CSUM_CLR_BIT] = csum_clr_r;
                end
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= wr_en || rd_en;
            o_pslverr <= (wr_en || rd_en) && !hit;
            o_prdata  <= (rd_en && hit) ? rd_data : 32'h0000_0000;
        end
    end

    // ------------
    // Global control and bank select
    // ------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            unit_en_r <= 1'b0;
            bank_r    <= BANK_RST;
        end else if (wr_en) begin
            if (i_paddr == CMD_CTL_OFS) begin
                unit_en_r <= i_pwdata[UNIT_EN_BIT];
            end
            if (i_paddr == BANK_SEL_OFS) begin
                bank_r <= i_pwdata[2:0];
            end
        end
    end

    // ------------
    // Port bank configuration
    // ------------
    // Settings are not locked while the unit is enabled; software is
    // trusted to change them only with the unit off.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            domain_r    <= DOMAIN_RST;
            domain_en_r <= 1'b0;
            alt_en_r    <= 1'b0;
            udp_byp_r   <= 1'b0;
            fcs_byp_r   <= 1'b0;
            version_r   <= VERSION_RST;
            msg_en_r    <= MSG_EN_RST;
        end else if (wr_en && port_bank && i_paddr == QUAL_CFG_OFS) begin
            domain_r    <= i_pwdata[DOMAIN_LSB +: 8];
            domain_en_r <= i_pwdata[DOMAIN_EN_BIT];
            alt_en_r    <= i_pwdata[ALT_EN_BIT];
            udp_byp_r   <= i_pwdata[UDP_BYP_BIT];
            fcs_byp_r   <= i_pwdata[FCS_BYP_BIT];
            version_r   <= i_pwdata[VERSION_LSB +: 4];
            msg_en_r    <= i_pwdata[15:0];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ta_ins_r   <= 1'b0;
            sync_ins_r <= 1'b0;
            rsvd_ofs_r <= RSVD_OFS_RST;
            csum_clr_r <= 1'b0;
        end else if (wr_en && port_bank) begin
            if (i_paddr == MOD_CFG_OFS) begin
                ta_ins_r   <= i_pwdata[TA_INS_BIT];
                sync_ins_r <= i_pwdata[SYNC_INS_BIT];
                rsvd_ofs_r <= i_pwdata[RSVD_OFS_LSB +: 6];
            end
            if (i_paddr == MOD_CFG2_OFS) begin
                csum_clr_r <= i_pwdata[CSUM_CLR_BIT];
            end
        end
    end

    // ------------
    // Header qualification
    // ------------
    logic hdr_pass;

    ptp_tx_qualify u_qualify (
        .i_msg_type_en   (msg_en_r),
        .i_exp_version   (version_r),
        .i_exp_domain    (domain_r),
        .i_domain_chk_en (domain_en_r),
        .i_alt_chk_en    (alt_en_r),
        .i_msg_type      (i_msg_type),
        .i_version       (i_version),
        .i_domain        (i_domain),
        .i_alt_master    (i_alt_master),
        .o_hdr_pass      (hdr_pass)
    );

    // ------------
    // Frame tracking and modification
    // ------------
    frame_state_t fr_state_r;
    logic         hdr_pass_r;
    logic         do_sync;
    logic         do_ta;
    logic         tail_ok;

    assign do_sync = sync_ins_r && (i_msg_type == MSG_SYNC);
    assign do_ta   = ta_ins_r && (i_msg_type == MSG_PDRESP);
    assign tail_ok = (i_fcs_ok || fcs_byp_r) &&
                     (i_udp_csum_ok || udp_byp_r);

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            fr_state_r <= FR_IDLE;
            hdr_pass_r <= 1'b0;
        end else begin
            case (fr_state_r)
                FR_IDLE: begin
                    if (i_hdr_valid) begin
                        fr_state_r <= FR_BODY;
                        hdr_pass_r <= hdr_pass && unit_en_r;
                    end
                end
                FR_BODY: begin
                    if (i_frame_end) begin
                        fr_state_r <= FR_IDLE;
                        hdr_pass_r <= 1'b0;
                    end
                end
                default: begin
                    fr_state_r <= FR_IDLE;
                    hdr_pass_r <= 1'b0;
                end
            endcase
        end
    end

    // Controls stand from the header strobe until the frame ends
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_insert_origin     <= 1'b0;
            o_insert_turnaround <= 1'b0;
            o_clear_udp_csum    <= 1'b0;
            o_reserved_offset   <= RSVD_OFS_RST;
            o_origin_ns         <= 30'h0000_0000;
            o_turnaround_ns     <= 30'h0000_0000;
        end else if (fr_state_r == FR_IDLE && i_hdr_valid) begin
            o_insert_origin     <= do_sync;
            o_insert_turnaround <= do_ta;
            o_clear_udp_csum    <= csum_clr_r && i_is_udp4 &&
                                   (do_sync || do_ta);
            o_reserved_offset   <= rsvd_ofs_r;
            o_origin_ns         <= i_egress_ns;
            o_turnaround_ns     <= ns_diff(i_egress_ns,
                                           i_pdreq_ingress_ns);
        end else if (fr_state_r == FR_BODY && i_frame_end) begin
            o_insert_origin     <= 1'b0;
            o_insert_turnaround <= 1'b0;
            o_clear_udp_csum    <= 1'b0;
        end
    end

    // ------------
    // Record or discard verdict
    // ------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_ts_record  <= 1'b0;
            o_ts_discard <= 1'b0;
        end else begin
            o_ts_record  <= fr_state_r == FR_BODY && i_frame_end &&
                            hdr_pass_r && tail_ok;
            o_ts_discard <= fr_state_r == FR_BODY && i_frame_end &&
                            !(hdr_pass_r && tail_ok);
        end
    end

    // Saturating counts; a verdict in the clearing cycle still counts
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rec_cnt_r  <= 8'h00;
            disc_cnt_r <= 8'h00;
        end else begin
            if (wr_en && i_paddr == STATUS_OFS) begin
                rec_cnt_r  <= {7'h00, o_ts_record};
                disc_cnt_r <= {7'h00, o_ts_discard};
            end else begin
                if (o_ts_record && rec_cnt_r != 8'hFF) begin
                    rec_cnt_r <= rec_cnt_r + 8'h01;
                end
                if (o_ts_discard && disc_cnt_r != 8'hFF) begin
                    disc_cnt_r <= disc_cnt_r + 8'h01;
                end
            end
        end
    end

endmodule : ptp_tx_ts_top

/* File: ptp_tx_pkg.sv */
/*
 * Constants for the transmit PTP timestamp qualify and modify block:
 * register offsets, field positions, reset values, message types.
 * Assumes a 12-bit APB byte address space with 32-bit data.
 */
package ptp_tx_pkg;

    // ------------
    // Register offsets (byte addresses)
    // ------------
    localparam int unsigned APB_AW        = 12;
    localparam logic [11:0] CMD_CTL_OFS   = 12'h000;
    localparam logic [11:0] BANK_SEL_OFS  = 12'h004;
    localparam logic [11:0] STATUS_OFS    = 12'h008;
    localparam logic [11:0] QUAL_CFG_OFS  = 12'h15C;
    localparam logic [11:0] MOD_CFG_OFS   = 12'h164;
    localparam logic [11:0] MOD_CFG2_OFS  = 12'h168;
    localparam logic [2:0]  PORT_BANK     = 3'h2;

    // ------------
    // Field positions
    // ------------
    localparam int unsigned DOMAIN_LSB    = 24;
    localparam int unsigned DOMAIN_EN_BIT = 23;
    localparam int unsigned ALT_EN_BIT    = 22;
    localparam int unsigned UDP_BYP_BIT   = 21;
    localparam int unsigned FCS_BYP_BIT   = 20;
    localparam int unsigned VERSION_LSB   = 16;
    localparam int unsigned TA_INS_BIT    = 29;
    localparam int unsigned SYNC_INS_BIT  = 28;
    localparam int unsigned RSVD_OFS_LSB  = 16;
    localparam int unsigned CSUM_CLR_BIT  = 0;
    localparam int unsigned UNIT_EN_BIT   = 0;

    // ------------
    // Reset values
    // ------------
    localparam logic [7:0]  DOMAIN_RST    = 8'h00;
    localparam logic [3:0]  VERSION_RST   = 4'h2;
    localparam logic [15:0] MSG_EN_RST    = 16'h0000;
    localparam logic [5:0]  RSVD_OFS_RST  = 6'h05;
    localparam logic [2:0]  BANK_RST      = 3'h0;

    // ------------
    // Message types and time arithmetic
    // ------------
    localparam logic [3:0]  MSG_SYNC      = 4'h0;
    localparam logic [3:0]  MSG_PDRESP    = 4'h3;
    localparam logic [29:0] NS_PER_SEC    = 30'h3B9ACA00;

    typedef enum logic [0:0] {
        FR_IDLE = 1'b0,
        FR_BODY = 1'b1
    } frame_state_t;

endpackage : ptp_tx_pkg

/* File: ptp_tx_qualify.sv */
/*
 * Header qualification for one outgoing PTP message.
 * Purely combinational; the instantiating block registers the result
 * and combines it with the end-of-frame FCS and UDP checksum verdicts.
 */
`timescale 1ns/1ps
module ptp_tx_qualify
    import ptp_tx_pkg::*;
(
    // Programmed settings
    input  wire logic [15:0] i_msg_type_en,
    input  wire logic [3:0]  i_exp_version,
    input  wire logic [7:0]  i_exp_domain,
    input  wire logic        i_domain_chk_en,
    input  wire logic        i_alt_chk_en,
    // Header fields of the message
    input  wire logic [3:0]  i_msg_type,
    input  wire logic [3:0]  i_version,
    input  wire logic [7:0]  i_domain,
    input  wire logic        i_alt_master,
    // Verdict
    output logic             o_hdr_pass
);

    logic type_ok;
    logic version_ok;
    logic domain_ok;
    logic alt_ok;

    always_comb begin
        type_ok    = i_msg_type_en[i_msg_type];
        // Zero accepts any version
        version_ok = (i_exp_version == 4'h0) ||
                     (i_exp_version == i_version);
        domain_ok  = !i_domain_chk_en || (i_domain == i_exp_domain);
        alt_ok     = !i_alt_chk_en || !i_alt_master;
        o_hdr_pass = type_ok && version_ok && domain_ok && alt_ok;
    end

endmodule : ptp_tx_qualify

/* File: ptp_tx_ts_top_monitor.sv */
/* Assertion checker for ptp_tx_ts_top.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module ptp_tx_ts_top_monitor
    import ptp_tx_pkg::*;
(
    // Clock, reset and bus
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        o_pready,
    input wire logic [31:0] o_prdata,
    // Frame path
    input wire logic        i_hdr_valid,
    input wire logic [29:0] i_egress_ns,
    input wire logic [29:0] i_pdreq_ingress_ns,
    input wire logic        i_frame_end,
    input wire logic        o_insert_origin,
    input wire logic        o_insert_turnaround,
    input wire logic        o_clear_udp_csum,
    input wire logic [29:0] o_origin_ns,
    input wire logic [29:0] o_turnaround_ns,
    input wire logic        o_ts_record,
    input wire logic        o_ts_discard
);
    logic        open_r;
    logic [29:0] ta_nxt;

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // Mirrors acceptance: a header while a frame is open is ignored
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            open_r <= 1'b0;
        end else if (!open_r && i_hdr_valid) begin
            open_r <= 1'b1;
        end else if (open_r && i_frame_end) begin
            open_r <= 1'b0;
        end
    end

    // Wraps at one second; 30-bit overflow cancels out
    assign ta_nxt = (i_egress_ns >= i_pdreq_ingress_ns) ? i_egress_ns - i_pdreq_ingress_ns
                  : i_egress_ns + NS_PER_SEC - i_pdreq_ingress_ns;

    // ------------
    // Properties
    // ------------
    sequence hdr_taken_s;
        i_hdr_valid && !open_r;
    endsequence
    sequence frame_closed_s;
        i_frame_end && open_r;
    endsequence
    sequence apb_taken_s;
        i_psel && i_penable && !o_pready;
    endsequence

    verdict_onehot_a: assert property (!(o_ts_record && o_ts_discard))
        else $error("record and discard together");
    verdict_per_frame_a: assert property (frame_closed_s |=> o_ts_record || o_ts_discard)
        else $error("no verdict after frame end");
    verdict_cause_a: assert property ((o_ts_record || o_ts_discard) |-> $past(i_frame_end))
        else $error("verdict without frame end");
    origin_latch_a: assert property (hdr_taken_s |=> o_origin_ns == $past(i_egress_ns))
        else $error("origin time not latched");
    turnaround_value_a: assert property (hdr_taken_s |=> o_turnaround_ns == $past(ta_nxt))
        else $error("turnaround time wrong");
    insert_hold_a: assert property (o_insert_origin && !i_frame_end |=> o_insert_origin)
        else $error("origin insertion dropped mid frame");
    clear_needs_insert_a: assert property (o_clear_udp_csum |-> o_insert_origin || o_insert_turnaround)
        else $error("checksum cleared without insertion");
    apb_answer_a: assert property (apb_taken_s |=> o_pready ##1 !o_pready)
        else $error("bus answer not one cycle");
    prdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h00000000)
        else $error("read data outside answer");
endmodule : ptp_tx_ts_top_monitor

bind ptp_tx_ts_top ptp_tx_ts_top_monitor ptp_tx_ts_top_monitor_i (
    .i_clk_sys, .i_rst, .i_psel, .i_penable, .o_pready, .o_prdata, .i_hdr_valid, .i_egress_ns,
    .i_pdreq_ingress_ns, .i_frame_end, .o_insert_origin, .o_insert_turnaround, .o_clear_udp_csum,
    .o_origin_ns, .o_turnaround_ns, .o_ts_record, .o_ts_discard);

/* File: ptp_tx_frame_src.sv */
/* Transmit frame path model: one PTP frame per go pulse.
   Assumes go is pulsed only after the previous frame has ended. */
`timescale 1ns/1ps
module ptp_tx_frame_src (
    // Control from the bench
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_go,
    input  wire logic [79:0] i_frame,
    input  wire logic [3:0]  i_len,
    // Frame path toward the block
    output logic             o_hdr_valid,
    output logic             o_frame_end,
    output logic [77:0]      o_hdr,
    output logic [1:0]       o_ok
);
    logic [79:0] frame_r;
    logic [3:0]  cnt_r;

    // Outside their strobe the fields show the inverse, never a stale copy
    assign o_hdr = o_hdr_valid ? frame_r[79:2] : ~frame_r[79:2];
    assign o_ok  = o_frame_end ? frame_r[1:0] : ~frame_r[1:0];

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            frame_r     <= 80'h0;
            cnt_r       <= 4'h0;
            o_hdr_valid <= 1'b0;
            o_frame_end <= 1'b0;
        end else begin
            o_hdr_valid <= i_go;
            o_frame_end <= cnt_r == 4'h1;
            if (i_go) begin
                frame_r <= i_frame;
                cnt_r   <= i_len;
            end else if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule : ptp_tx_frame_src

/* File: test_ptp_tx_ts_top.sv */
/* Self-checking bench for ptp_tx_ts_top: a table of frames, then bus corners and resets.
   Assumes the frame source model and the bound monitor are compiled before it. */
`timescale 1ns/1ps
module test_ptp_tx_ts_top;
    import ptp_tx_pkg::*;
    typedef struct {
        logic [31:0] q;
        logic [31:0] m;
        logic [3:0]  ty;
        logic [3:0]  ve;
        logic [7:0]  dm;
        logic        al;
        logic [2:0]  fl;
        logic        rec;
    } row_t;
    localparam logic [29:0] IN_NS = 30'h3B9AC99C;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        go = 1'b0;
    logic [79:0] frame = 80'h0;
    logic [3:0]  len = 4'h3;
    logic        hv, fe, ready, slverr, io, it, clr, rec, dis, rerr, ex_o, ex_t;
    logic [1:0]  ok, vd;
    logic [77:0] hdr;
    logic [31:0] prdata, rdat;
    logic [29:0] org, ta, eg;
    logic [5:0]  ofs;
    logic [68:0] cap;
    int          n_errors = 0;
    int          checks = 0;
    row_t        r;
    // Fields: qualify cfg, modify cfg (bit 0 goes to the second register), type, version, domain,
    // alt flag, {udp4, fcs ok, udp ok}, recorded
    row_t rows[15] = '{
        '{32'h0582000F, 32'h00050000, 4'h0, 4'h2, 8'h05, 1'b0, 3'h3, 1'b1},
        '{32'h0582000F, 32'h00050000, 4'h1, 4'h2, 8'h06, 1'b0, 3'h3, 1'b0},
        '{32'h05C2000F, 32'h00050000, 4'h2, 4'h2, 8'h05, 1'b1, 3'h3, 1'b0},
        '{32'h0582000F, 32'h00050000, 4'h2, 4'h2, 8'h05, 1'b1, 3'h3, 1'b1},
        '{32'h0582000F, 32'h00050000, 4'h3, 4'h2, 8'h05, 1'b0, 3'h2, 1'b0},
        '{32'h05A2000F, 32'h00050000, 4'h3, 4'h2, 8'h05, 1'b0, 3'h2, 1'b1},
        '{32'h0582000F, 32'h00050000, 4'h0, 4'h2, 8'h05, 1'b0, 3'h1, 1'b0},
        '{32'h0592000F, 32'h00050000, 4'h0, 4'h2, 8'h05, 1'b0, 3'h1, 1'b1},
        '{32'h0582000F, 32'h00050000, 4'h0, 4'h3, 8'h05, 1'b0, 3'h3, 1'b0},
        '{32'h0580000F, 32'h00050000, 4'h0, 4'h7, 8'h05, 1'b0, 3'h3, 1'b1},
        '{32'h0582000F, 32'h00050000, 4'h4, 4'h2, 8'h05, 1'b0, 3'h3, 1'b0},
        '{32'h05828000, 32'h00050000, 4'hF, 4'h2, 8'h05, 1'b0, 3'h3, 1'b1},
        '{32'h00020008, 32'h200A0001, 4'h3, 4'h2, 8'h7A, 1'b0, 3'h7, 1'b1},
        '{32'h0582000F, 32'h10000001, 4'h0, 4'h2, 8'h05, 1'b0, 3'h7, 1'b1},
        '{32'h0582000F, 32'h30000000, 4'h0, 4'h2, 8'h05, 1'b0, 3'h7, 1'b1}};

    always #50 clk = ~clk;

    ptp_tx_frame_src ptp_tx_frame_src_i (.i_clk_sys(clk), .i_rst(rst), .i_go(go), .i_frame(frame),
        .i_len(len), .o_hdr_valid(hv), .o_frame_end(fe), .o_hdr(hdr), .o_ok(ok));
    ptp_tx_ts_top ptp_tx_ts_top_i (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(ready), .o_prdata(prdata),
        .o_pslverr(slverr), .i_hdr_valid(hv), .i_msg_type(hdr[77:74]), .i_version(hdr[73:70]),
        .i_domain(hdr[69:62]), .i_alt_master(hdr[61]), .i_is_udp4(hdr[60]), .i_egress_ns(hdr[59:30]),
        .i_pdreq_ingress_ns(hdr[29:0]), .i_frame_end(fe), .i_fcs_ok(ok[1]), .i_udp_csum_ok(ok[0]),
        .o_insert_origin(io), .o_insert_turnaround(it), .o_clear_udp_csum(clr), .o_reserved_offset(ofs),
        .o_origin_ns(org), .o_turnaround_ns(ta), .o_ts_record(rec), .o_ts_discard(dis));

    task automatic give_verdict;
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (ready === 1'b1) break;
        end
        rdat = prdata;
        rerr = slverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20) begin
            n_errors++;
            give_verdict();
        end
    endtask : apb

    task automatic send(input logic [79:0] f);
        int k;
        @(posedge clk);
        go <= 1'b1;
        frame <= f;
        @(posedge clk);
        go <= 1'b0;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (fe === 1'b1) cap = {io, it, clr, ofs, org, ta};
            if (rec === 1'b1 || dis === 1'b1) break;
        end
        vd = {rec, dis};
        if (k == 40) begin
            n_errors++;
            give_verdict();
        end
    endtask : send

    task automatic do_reset;
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        cmp(32'(ofs), 32'h5);
        apb(1'b0, QUAL_CFG_OFS, 32'h0);
        cmp(32'(rerr), 32'h1);
        apb(1'b1, BANK_SEL_OFS, {29'h0, PORT_BANK});
        apb(1'b0, QUAL_CFG_OFS, 32'h0);
        cmp(rdat, 32'h00020000);
        apb(1'b0, MOD_CFG_OFS, 32'h0);
        cmp(rdat, 32'h00050000);
        apb(1'b0, MOD_CFG2_OFS, 32'h0);
        cmp(rdat, 32'h00000000);
    endtask : do_reset

    // ------------
    // Scenarios
    // ------------
    initial begin
        do_reset();
        foreach (rows[i]) begin
            r = rows[i];
            eg = {r.dm, r.ty, 18'h00064};
            apb(1'b1, CMD_CTL_OFS, 32'h0);
            apb(1'b1, QUAL_CFG_OFS, r.q);
            apb(1'b1, MOD_CFG_OFS, r.m);
            apb(1'b1, MOD_CFG2_OFS, {31'h0, r.m[0]});
            apb(1'b1, CMD_CTL_OFS, 32'h1);
            send({r.ty, r.ve, r.dm, r.al, r.fl[2], eg, IN_NS, r.fl[1:0]});
            ex_o = r.m[SYNC_INS_BIT] && r.ty == MSG_SYNC;
            ex_t = r.m[TA_INS_BIT] && r.ty == MSG_PDRESP;
            cmp(32'(cap[68]), 32'(ex_o));
            cmp(32'(cap[67]), 32'(ex_t));
            cmp(32'(cap[66]), 32'(r.m[0] && r.fl[2] && (ex_o || ex_t)));
            cmp(32'(cap[65:60]), 32'(r.m[21:16]));
            cmp(32'(cap[59:30]), 32'(eg));
            // Every row's egress is below the request time, so the difference wraps
            cmp(32'(cap[29:0]), 32'(eg + NS_PER_SEC - IN_NS));
            cmp(32'(vd), {30'h0, r.rec, !r.rec});
        end
        apb(1'b1, CMD_CTL_OFS, 32'h0);
        len <= 4'h1;
        send({MSG_SYNC, 4'h2, 8'h05, 1'b0, 1'b0, 30'h64, IN_NS, 2'h3});
        cmp(32'(vd), 32'h1);
        apb(1'b0, STATUS_OFS, 32'h0);
        cmp(rdat, 32'h00000709);
        apb(1'b1, BANK_SEL_OFS, 32'h3);
        apb(1'b1, QUAL_CFG_OFS, 32'hFFFFFFFF);
        cmp(32'(rerr), 32'h1);
        apb(1'b1, BANK_SEL_OFS, {29'h0, PORT_BANK});
        apb(1'b0, QUAL_CFG_OFS, 32'h0);
        cmp(rdat, 32'h0582000F);
        apb(1'b0, 12'h0FC, 32'h0);
        cmp(32'(rerr), 32'h1);
        apb(1'b1, MOD_CFG_OFS, 32'hFFFFFFFF);
        apb(1'b0, MOD_CFG_OFS, 32'h0);
        cmp(rdat, 32'h303F0000);
        apb(1'b1, MOD_CFG2_OFS, 32'hFFFFFFFF);
        apb(1'b0, MOD_CFG2_OFS, 32'h0);
        cmp(rdat, 32'h00000001);
        do_reset();
        give_verdict();
    end
endmodule : test_ptp_tx_ts_top
